// ### hw/preview_regs.vh
// register offsets, field limits, reset values and pitch constants of the preview oscillator
`ifndef PREVIEW_REGS_VH
`define PREVIEW_REGS_VH

`define OFS_PREV 8'h00
`define OFS_VMOD 8'h04
`define OFS_PMOD 8'h08
`define OFS_HARM 8'h0c
`define OFS_OCT 8'h10
`define OFS_TONE 8'h14
`define OFS_MODE 8'h18
`define OFS_PRESET 8'h1c
`define OFS_STATUS 8'h20
`define OFS_PITCH 8'h24

`define PREV_MAX 8'd63
`define VMOD_LIM 8'd63
`define PMOD_LIM 8'd63
`define HARM_LIM 8'd31
`define OCT_LIM 8'd7
`define TONE_LIM 8'd31
`define MODE_MAX 8'd12
`define MODE_DC 4'hc

`define RST_PREV 6'h20
`define RST_VMOD 7'h00
`define RST_PMOD 7'h00
`define RST_HARM 6'h00
`define RST_OCT 4'h0
`define RST_TONE 6'h00
`define RST_MODE 4'h0

`define PRESET_STORE_BIT 8
`define PRESET_LOAD_BIT 9

`define VMOD_UNITY_SHIFT 5
`define PMOD_SHIFT 12
`define LEVEL_SHIFT 6
`define GAIN_FULL 255
`define PITCH_A440 16'h6900
`define OCTAVE_SHIFT 12
`define SEMITONE 341

`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11

`endif

// ### hw/preview_preset_mem.v
// preset store for the preview settings, registered read port
`timescale 1ns/1ps
module preview_preset_mem #(
    parameter WIDTH = 40,
    parameter DEPTH_LOG2 = 4
) (
    input wire ref_clk,
    input wire wrEn,
    input wire [DEPTH_LOG2-1:0] wrAddr,
    input wire [WIDTH-1:0] wrData,
    input wire [DEPTH_LOG2-1:0] rdAddr,
    output reg [WIDTH-1:0] rdData
);
    reg [WIDTH-1:0] mem [0:(1<<DEPTH_LOG2)-1];

    always @(posedge ref_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule

// ### hw/preview_level_calc.v
// preview level from base level, volume-hand and pitch-hand modulation
`timescale 1ns/1ps
`include "preview_regs.vh"
module preview_level_calc (
    input wire [7:0] voiceVol,
    input wire [15:0] pitch,
    input wire [5:0] prev,
    input wire [6:0] vmod,
    input wire [6:0] pmod,
    output reg [7:0] level
);
    reg signed [9:0] diff;
    reg signed [17:0] vprod;
    reg signed [17:0] delta;
    reg signed [25:0] pprod;
    reg signed [19:0] gain;
    reg [7:0] gainSat;
    reg [13:0] prod;

    always @* begin
        // positive: rises with volume, unity at 32; negative: falls as volume rises
        diff = $signed(vmod) >= 0 ? $signed({2'b00, voiceVol}) - 10'sd255
                                  : $signed({2'b00, voiceVol});
        vprod = $signed(vmod) * diff;
        // zero setting leaves the full base level untouched
        gain = 20'sd255 + (vprod >>> `VMOD_UNITY_SHIFT);
        delta = $signed({2'b00, pitch}) - $signed({2'b00, `PITCH_A440});
        pprod = $signed(pmod) * delta;
        gain = gain + $signed(pprod[25:`PMOD_SHIFT]);
        if (gain < 0) begin
            gainSat = 8'h00;
        end else if (gain > `GAIN_FULL) begin
            gainSat = 8'hff;
        end else begin
            gainSat = gain[7:0];
        end
        prod = prev * gainSat;
        level = prod[13:`LEVEL_SHIFT];
    end
endmodule

// ### hw/pitch_preview_oscillator.v
// preview oscillator control: settings, level, pitch, tone and output routing
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "preview_regs.vh"
// Overview of operation
// - Preview amplitude scales with the base level setting, range 0 to 63.
// - Positive volume modulation raises level with volume; 32 tracks voice volume.
// - Negative volume modulation raises level as volume falls, ducking the preview.
// - Zero volume modulation keeps the level constant.
// - Pitch modulation raises level with pitch or falling pitch; pivot at A440.
// - Harmonic magnitude sets harmonic level; negative means odd harmonics only.
// - Octave setting offsets preview pitch from oscillator octave, bank adds more.
// - Tone boosts or cuts lows and highs together.
// - In mode twelve tone steers treble only, bass stays flat.
// - Preview goes to monitor outputs and osc4 injection, never to line outputs.
// - Fourth-oscillator modes send the preview into the oscillator section.
// - Modes 0 to 11 route in groups of four by offset.
// - Modes 0-3 correct pitch, 4-7 plain, 8-11 hard quantize.
// - Correction equals the voice's; hard quantizing ignores that correction.
// - Mode twelve injects a DC stimulus, synth on both monitor channels.
// - Settings are saved and loaded per voice preset.
module pitch_preview_oscillator #(
    parameter PRESET_LOG2 = 4
) (
    input wire ref_clk,
    input wire arst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire sampleStb,
    input wire [7:0] voiceVol,
    input wire [15:0] rawPitch,
    input wire [15:0] corrPitch,
    input wire [3:0] oscOct,
    input wire [3:0] bankOct,
    input wire [15:0] previewWave,
    input wire [15:0] synthL,
    input wire [15:0] synthR,
    output reg [15:0] monitorL,
    output reg [15:0] monitorR,
    output reg [15:0] lineL,
    output reg [15:0] lineR,
    output reg [15:0] osc4Inject,
    output reg osc4Active,
    output reg dcStimActive,
    output reg [15:0] previewPitch,
    output reg [4:0] harmLevel,
    output reg oddHarmOnly,
    output reg [5:0] bassGain,
    output reg [5:0] trebGain
);
    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function [7:0] sat;
        input [31:0] v;
        input [7:0] lim;
        input neg;
        begin
            if ($signed(v) > $signed({24'h000000, lim})) begin
                sat = lim;
            end else if (!neg && $signed(v) < 0) begin
                sat = 8'h00;
            end else if (neg && $signed(v) < -$signed({24'h000000, lim})) begin
                sat = 8'h00 - lim;
            end else begin
                sat = v[7:0];
            end
        end
    endfunction

    // route flags {synthL, synthR, prevL, prevR, osc4, correct, quantize, dc}
    function [7:0] route;
        input [3:0] m;
        begin
            if (m == `MODE_DC) begin
                route = 8'b1100_0001;
            end else begin
                case (m[1:0])
                    2'd0: route = 8'b1100_1000;
                    2'd1: route = 8'b1001_0000;
                    2'd2: route = 8'b1111_0000;
                    default: route = 8'b0011_0000;
                endcase
                route[2] = (m[3:2] == 2'd0);
                route[1] = (m[3:2] == 2'd2);
            end
        end
    endfunction

    function [15:0] sat16;
        input signed [17:0] v;
        begin
            if (v > 18'sd32767) begin
                sat16 = 16'h7fff;
            end else if (v < -18'sd32768) begin
                sat16 = 16'h8000;
            end else begin
                sat16 = v[15:0];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // settings and bus slave

    reg [5:0] prevQ;
    reg [6:0] vmodQ;
    reg [6:0] pmodQ;
    reg [5:0] harmQ;
    reg [3:0] octQ;
    reg [5:0] toneQ;
    reg [3:0] modeQ;
    reg awHeldQ;
    reg wHeldQ;
    reg [7:0] awAddrQ;
    reg [31:0] wDataQ;
    reg wLowQ;
    reg loadPendQ;
    reg [PRESET_LOG2-1:0] presetIdxQ;
    reg [7:0] levelQ;
    wire [39:0] memRd;
    wire [7:0] level;
    wire [7:0] flags;
    reg wrHit;
    reg [7:0] wrSat;
    reg memWr;
    reg [31:0] rdMux;
    reg rdHit;

    assign flags = route(modeQ);

    always @* begin
        wrHit = 1'b1;
        case (awAddrQ)
            `OFS_PREV: wrSat = sat(wDataQ, `PREV_MAX, 1'b0);
            `OFS_VMOD: wrSat = sat(wDataQ, `VMOD_LIM, 1'b1);
            `OFS_PMOD: wrSat = sat(wDataQ, `PMOD_LIM, 1'b1);
            `OFS_HARM: wrSat = sat(wDataQ, `HARM_LIM, 1'b1);
            `OFS_OCT: wrSat = sat(wDataQ, `OCT_LIM, 1'b1);
            `OFS_TONE: wrSat = sat(wDataQ, `TONE_LIM, 1'b1);
            `OFS_MODE: wrSat = sat(wDataQ, `MODE_MAX, 1'b0);
            `OFS_PRESET: wrSat = 8'h00;
            default: begin
                wrSat = 8'h00;
                wrHit = 1'b0;
            end
        endcase
        memWr = awHeldQ && wHeldQ && !s_axi_bvalid && wLowQ && awAddrQ == `OFS_PRESET
            && wDataQ[`PRESET_STORE_BIT];
        rdHit = 1'b1;
        case (s_axi_araddr)
            `OFS_PREV: rdMux = {26'h0, prevQ};
            `OFS_VMOD: rdMux = {{25{vmodQ[6]}}, vmodQ};
            `OFS_PMOD: rdMux = {{25{pmodQ[6]}}, pmodQ};
            `OFS_HARM: rdMux = {{26{harmQ[5]}}, harmQ};
            `OFS_OCT: rdMux = {{28{octQ[3]}}, octQ};
            `OFS_TONE: rdMux = {{26{toneQ[5]}}, toneQ};
            `OFS_MODE: rdMux = {28'h0, modeQ};
            `OFS_PRESET: rdMux = {22'h0, loadPendQ, 5'h0, {(4-PRESET_LOG2){1'b0}},
                presetIdxQ};
            `OFS_STATUS: rdMux = {16'h0, flags, levelQ};
            `OFS_PITCH: rdMux = {16'h0, previewPitch};
            default: begin
                rdMux = 32'h0;
                rdHit = 1'b0;
            end
        endcase
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_OKAY;
            awHeldQ <= 1'b0;
            wHeldQ <= 1'b0;
            awAddrQ <= 8'h00;
            wDataQ <= 32'h0;
            wLowQ <= 1'b0;
            loadPendQ <= 1'b0;
            presetIdxQ <= {PRESET_LOG2{1'b0}};
            prevQ <= `RST_PREV;
            vmodQ <= `RST_VMOD;
            pmodQ <= `RST_PMOD;
            harmQ <= `RST_HARM;
            octQ <= `RST_OCT;
            toneQ <= `RST_TONE;
            modeQ <= `RST_MODE;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awHeldQ <= 1'b1;
                awAddrQ <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wHeldQ <= 1'b1;
                wDataQ <= s_axi_wdata;
                wLowQ <= s_axi_wstrb[0];
            end
            loadPendQ <= 1'b0;
            if (loadPendQ) begin
                {prevQ, vmodQ, pmodQ, harmQ, octQ, toneQ, modeQ} <= memRd;
            end
            if (awHeldQ && wHeldQ && !s_axi_bvalid) begin
                awHeldQ <= 1'b0;
                wHeldQ <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit ? `RESP_OKAY : `RESP_DECERR;
                if (wLowQ) begin
                    case (awAddrQ)
                        `OFS_PREV: prevQ <= wrSat[5:0];
                        `OFS_VMOD: vmodQ <= wrSat[6:0];
                        `OFS_PMOD: pmodQ <= wrSat[6:0];
                        `OFS_HARM: harmQ <= wrSat[5:0];
                        `OFS_OCT: octQ <= wrSat[3:0];
                        `OFS_TONE: toneQ <= wrSat[5:0];
                        `OFS_MODE: modeQ <= wrSat[3:0];
                        `OFS_PRESET: begin
                            presetIdxQ <= wDataQ[PRESET_LOG2-1:0];
                            loadPendQ <= wDataQ[`PRESET_LOAD_BIT] &&
                                !wDataQ[`PRESET_STORE_BIT];
                        end
                        default: begin
                        end
                    endcase
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdMux;
                s_axi_rresp <= rdHit ? `RESP_OKAY : `RESP_DECERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // store writes the live settings; load reads the slot named in the same word
    preview_preset_mem #(
        .WIDTH(40),
        .DEPTH_LOG2(PRESET_LOG2)
    ) presets (
        .ref_clk(ref_clk),
        .wrEn(memWr),
        .wrAddr(wDataQ[PRESET_LOG2-1:0]),
        .wrData({prevQ, vmodQ, pmodQ, harmQ, octQ, toneQ, modeQ}),
        .rdAddr(wDataQ[PRESET_LOG2-1:0]),
        .rdData(memRd)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // level, pitch and tone

    preview_level_calc levelCalc (
        .voiceVol(voiceVol),
        .pitch(rawPitch),
        .prev(prevQ),
        .vmod(vmodQ),
        .pmod(pmodQ),
        .level(level)
    );

    reg [15:0] quantPitch;
    reg [15:0] basePitch;
    reg signed [5:0] octSum;
    reg signed [18:0] pitchSum;
    reg signed [31:0] waveProd;
    reg signed [17:0] prevAudio;
    reg [16:0] roundUp;
    reg [31:0] quantFull;
    localparam [16:0] HALF_STEP = `SEMITONE / 2;

    always @* begin
        roundUp = {1'b0, rawPitch} + HALF_STEP;
        // pitch is unsigned: clamp at the top of the range, not at the signed limit
        quantFull = roundUp / `SEMITONE * `SEMITONE;
        quantPitch = (quantFull > 32'd65535) ? 16'hffff : quantFull[15:0];
        if (flags[1]) begin
            basePitch = quantPitch;
        end else if (flags[2]) begin
            basePitch = corrPitch;
        end else begin
            basePitch = rawPitch;
        end
        octSum = $signed({{2{oscOct[3]}}, oscOct}) + $signed({{2{octQ[3]}}, octQ})
            + $signed({{2{bankOct[3]}}, bankOct});
        pitchSum = $signed({3'b000, basePitch}) + ($signed({{13{octSum[5]}}, octSum})
            <<< `OCTAVE_SHIFT);
        waveProd = $signed(previewWave) * $signed({1'b0, levelQ});
        prevAudio = waveProd[25:8];
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            levelQ <= 8'h00;
            previewPitch <= 16'h0;
            monitorL <= 16'h0;
            monitorR <= 16'h0;
            lineL <= 16'h0;
            lineR <= 16'h0;
            osc4Inject <= 16'h0;
            osc4Active <= 1'b0;
            dcStimActive <= 1'b0;
            harmLevel <= 5'h0;
            oddHarmOnly <= 1'b0;
            bassGain <= 6'h0;
            trebGain <= 6'h0;
        end else begin
            harmLevel <= harmQ[5] ? 5'h0 - harmQ[4:0] : harmQ[4:0];
            oddHarmOnly <= harmQ[5];
            trebGain <= toneQ;
            bassGain <= (modeQ == `MODE_DC) ? 6'h00 : toneQ;
            osc4Active <= flags[3];
            dcStimActive <= flags[0];
            if (sampleStb) begin
                levelQ <= level;
                if (pitchSum < 0) begin
                    previewPitch <= 16'h0;
                end else if (pitchSum > 19'sd65535) begin
                    previewPitch <= 16'hffff;
                end else begin
                    previewPitch <= pitchSum[15:0];
                end
                lineL <= synthL;
                lineR <= synthR;
                monitorL <= sat16((flags[7] ? $signed({{2{synthL[15]}}, synthL}) : 18'sd0)
                    + (flags[5] ? prevAudio : 18'sd0));
                monitorR <= sat16((flags[6] ? $signed({{2{synthR[15]}}, synthR}) : 18'sd0)
                    + (flags[4] ? prevAudio : 18'sd0));
                if (flags[0]) begin
                    osc4Inject <= {1'b0, levelQ, 7'h00};
                end else if (flags[3]) begin
                    osc4Inject <= sat16(prevAudio);
                end else begin
                    osc4Inject <= 16'h0;
                end
            end
        end
    end
endmodule

// ### tb/audio_source_model.sv
// voice audio and sample strobe source facing the preview block
`timescale 1ns/1ps
module audio_source_model #(
    parameter PERIOD = 8
) (
    input wire ref_clk,
    input wire arst_n,
    output reg sampleStb,
    output reg [15:0] synthL,
    output reg [15:0] synthR,
    output wire [15:0] previewWave
);
reg [3:0] cnt_q;
// steady preview waveform keeps the expected audio easy to work out
assign previewWave = 16'h1000;
always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
        cnt_q <= 4'h0;
        sampleStb <= 1'b0;
        synthL <= 16'h0100;
        synthR <= 16'hff00;
    end else begin
        cnt_q <= (cnt_q == PERIOD - 1) ? 4'h0 : cnt_q + 4'h1;
        sampleStb <= (cnt_q == PERIOD - 1);
        // voice moves every sample so a stale mix shows up
        if (sampleStb) begin
            synthL <= synthL + 16'h0011;
            synthR <= synthR - 16'h0013;
        end
    end
end
endmodule

// ### tb/pitch_preview_chk.sv
// port assertions of the preview oscillator
`timescale 1ns/1ps
module pitch_preview_chk (
    input wire ref_clk,
    input wire arst_n,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire sampleStb,
    input wire [15:0] synthL,
    input wire [15:0] synthR,
    input wire [15:0] lineL,
    input wire [15:0] lineR,
    input wire [4:0] harmLevel,
    input wire oddHarmOnly,
    input wire [5:0] bassGain,
    input wire [5:0] trebGain
);
default clocking cb @(posedge ref_clk);
endclocking
default disable iff (!arst_n);
chk_line_left: assert property (sampleStb |=> lineL == $past(synthL))
    else $error("line left is not the voice");
chk_line_right: assert property (sampleStb |=> lineR == $past(synthR))
    else $error("line right is not the voice");
chk_odd_magnitude: assert property (oddHarmOnly |-> harmLevel != 5'h00)
    else $error("odd harmonics with zero level");
chk_tone_pair: assert property (bassGain != trebGain |-> bassGain == 6'h00)
    else $error("bass and treble split");
chk_tone_range: assert property (bassGain != 6'h20 && trebGain != 6'h20)
    else $error("tone gain out of range");
chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
endmodule
bind pitch_preview_oscillator pitch_preview_chk chk (.ref_clk(ref_clk), .arst_n(arst_n),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .sampleStb(sampleStb), .synthL(synthL), .synthR(synthR), .lineL(lineL), .lineR(lineR),
    .harmLevel(harmLevel), .oddHarmOnly(oddHarmOnly), .bassGain(bassGain),
    .trebGain(trebGain));

// ### tb/pitch_preview_oscillator_bench.sv
// self-checking bench of the preview oscillator
`timescale 1ns/1ps
module pitch_preview_oscillator_bench;
reg ref_clk = 1'b0;
reg arst_n = 1'b0;
reg [7:0] awA = 8'h00, arA = 8'h00, vVol = 8'h80;
reg [3:0] oOct = 4'h0;
reg [15:0] expL, expR;
reg [31:0] wD = 32'h0, rb;
reg awV = 1'b0, wV = 1'b0, bRd = 1'b0, arV = 1'b0, rRd = 1'b0;
reg [15:0] raw = 16'h6900, corr = 16'h6910, lastL = 16'h0, lastR = 16'h0;
wire awR, wR, bV, arR, rV, stb, osc4, dc, odd;
wire [1:0] bRsp, rRsp;
wire [31:0] rD;
wire [15:0] sL, sR, pw, monL, monR, lnL, lnR, inj, pp;
wire [4:0] hl;
wire [5:0] bg, tg;
integer num_errors = 0;
integer total_checks = 0;
integer m;
reg [7:0] r;
// route flags per mode, mode 12 in the top byte
localparam [103:0] ROUTES = {8'hc1, 8'h32, 8'hf2, 8'h92, 8'hca, 8'h30, 8'hf0, 8'h90,
    8'hc8, 8'h34, 8'hf4, 8'h94, 8'hcc};
pitch_preview_oscillator dut (.ref_clk(ref_clk), .arst_n(arst_n), .s_axi_awaddr(awA),
    .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bRsp), .s_axi_bvalid(bV),
    .s_axi_bready(bRd), .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arR),
    .s_axi_rdata(rD), .s_axi_rresp(rRsp), .s_axi_rvalid(rV), .s_axi_rready(rRd),
    .sampleStb(stb), .voiceVol(vVol), .rawPitch(raw), .corrPitch(corr), .oscOct(oOct),
    .bankOct(4'h1), .previewWave(pw), .synthL(sL), .synthR(sR), .monitorL(monL),
    .monitorR(monR), .lineL(lnL), .lineR(lnR), .osc4Inject(inj), .osc4Active(osc4),
    .dcStimActive(dc), .previewPitch(pp), .harmLevel(hl), .oddHarmOnly(odd),
    .bassGain(bg), .trebGain(tg));
audio_source_model partner (.ref_clk(ref_clk), .arst_n(arst_n), .sampleStb(stb),
    .synthL(sL), .synthR(sR), .previewWave(pw));
always #5 ref_clk = ~ref_clk;
// voice sample that the design used at each strobe
always @(posedge ref_clk) begin
    if (stb) begin
        lastL <= sL;
        lastR <= sR;
    end
end
task check(input string nm, input [31:0] seen, input [31:0] exp);
    begin
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    end
endtask
task w(input integer n);
    begin
        repeat (n) @(posedge ref_clk);
        #1;
    end
endtask
task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    integer n;
    begin
        @(posedge ref_clk);
        awA <= a;
        wD <= d;
        awV <= 1'b1;
        wV <= 1'b1;
        bRd <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n = n + 1;
            if (awR) awV <= 1'b0;
            if (wR) wV <= 1'b0;
        end while (!bV && n < 50);
        bRd <= 1'b0;
        check("write answer", n < 50, 1);
        check("bresp", bRsp, er);
    end
endtask
task rd(input [7:0] a, input [1:0] er, output [31:0] q);
    integer n;
    begin
        @(posedge ref_clk);
        arA <= a;
        arV <= 1'b1;
        rRd <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n = n + 1;
            if (arR) arV <= 1'b0;
        end while (!rV && n < 50);
        q = rD;
        rRd <= 1'b0;
        check("read answer", n < 50, 1);
        check("rresp", rRsp, er);
    end
endtask
task wrchk(input [7:0] a, input [31:0] d, input [31:0] e);
    begin
        wr(a, d, 2'b00);
        rd(a, 2'b00, rb);
        check("readback", rb, e);
    end
endtask
task lv(input [7:0] vv, input [31:0] vm, input [31:0] pm, input [15:0] p, input [7:0] e);
    begin
        @(posedge ref_clk);
        vVol <= vv;
        raw <= p;
        wr(8'h04, vm, 2'b00);
        wr(8'h08, pm, 2'b00);
        w(40);
        rd(8'h20, 2'b00, rb);
        check("level", rb[7:0], e);
    end
endtask
task pt(input [31:0] md, input [15:0] e);
    begin
        wr(8'h18, md, 2'b00);
        w(30);
        check("pitch", pp, e);
    end
endtask
task wrap_up;
    begin
        if (num_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    end
endtask
initial begin
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(8'h00, 2'b00, rb);
    check("prev reset", rb, 32'h20);
    rd(8'h18, 2'b00, rb);
    check("mode reset", rb, 32'h0);
    wrchk(8'h00, 32'd100, 32'd63);
    wrchk(8'h04, 32'hffffff38, 32'hffffffc1);
    wrchk(8'h0c, 32'd40, 32'd31);
    wrchk(8'h14, 32'hffffff9c, 32'hffffffe1);
    wrchk(8'h18, 32'd20, 32'd12);
    lv(8'h80, 32'h0, 32'h0, 16'h6900, 8'hfb);
    wr(8'h00, 32'd32, 2'b00);
    lv(8'h80, 32'd32, 32'h0, 16'h6900, 8'h40);
    lv(8'hff, 32'd32, 32'h0, 16'h6900, 8'h7f);
    lv(8'h80, 32'hffffffe0, 32'h0, 16'h6900, 8'h3f);
    lv(8'h80, 32'd32, 32'd32, 16'h7900, 8'h50);
    lv(8'h80, 32'd32, 32'hffffffe0, 16'h7900, 8'h30);
    lv(8'h00, 32'h0, 32'h0, 16'h6900, 8'h7f);
    for (m = 0; m < 13; m = m + 1) begin
        wr(8'h18, m, 2'b00);
        w(30);
        r = ROUTES[m*8 +: 8];
        expL = (r[7] ? lastL : 16'h0) + (r[5] ? 16'h07f0 : 16'h0);
        expR = (r[6] ? lastR : 16'h0) + (r[4] ? 16'h07f0 : 16'h0);
        check("monitor left", monL, expL);
        check("monitor right", monR, expR);
        check("osc4 dc flags", {osc4, dc}, {r[3], r[0]});
        check("inject", inj, m == 12 ? 16'h3f80 : (r[3] ? 16'h07f0 : 16'h0));
        check("line", {lnL, lnR}, {lastL, lastR});
        rd(8'h20, 2'b00, rb);
        check("route", rb[15:8] & (m == 12 ? 8'hf7 : 8'hff), r);
    end
    wr(8'h10, 32'd1, 2'b00);
    pt(32'd4, 16'h8900);
    pt(32'd0, 16'h8910);
    pt(32'd8, 16'h893b);
    wr(8'h10, 32'hffffff38, 2'b00);
    pt(32'd4, 16'h0900);
    @(posedge ref_clk);
    oOct <= 4'hf;
    pt(32'd4, 16'h0000);
    @(posedge ref_clk);
    raw <= 16'hf000;
    pt(32'd8, 16'h7fc4);
    wr(8'h0c, 32'hfffffffb, 2'b00);
    w(2);
    check("harm odd", {odd, hl}, {1'b1, 5'd5});
    wr(8'h0c, 32'd9, 2'b00);
    w(2);
    check("harm all", {odd, hl}, {1'b0, 5'd9});
    wr(8'h14, 32'hfffffff9, 2'b00);
    w(2);
    check("tone", {bg, tg}, {6'h39, 6'h39});
    wr(8'h18, 32'd12, 2'b00);
    w(2);
    check("tone dc", {bg, tg}, {6'h00, 6'h39});
    wr(8'h00, 32'd10, 2'b00);
    wr(8'h1c, 32'h103, 2'b00);
    wr(8'h00, 32'd50, 2'b00);
    wr(8'h1c, 32'h203, 2'b00);
    w(4);
    rd(8'h00, 2'b00, rb);
    check("preset", rb, 32'd10);
    wr(8'h30, 32'h1, 2'b11);
    wr(8'h20, 32'h1, 2'b11);
    rd(8'h30, 2'b11, rb);
    check("unmapped", rb, 32'h0);
    wrap_up;
end
initial begin
    #100000;
    num_errors = num_errors + 1;
    wrap_up;
end
endmodule
